// ===== logic/pus_pkg.sv
// Purpose: Constants and types for the power-up reset sequencer
// Assumes: clk is the oscillator clock at 250 MHz; one bus word per register
// Notes: Cycle counts below are in clk cycles
// Summary of operation
// - Sequence starts only with both supplies good and power-on reset released.
// - Oscillator start-up is the first phase after power-on reset release.
// - Phases in order: oscillator 1032, fuse load 1160, pump 688 cycles.
// - After bank power-up of 617 cycles release CPU reset, boot at zero.
// - Power-on reset lows under 475 ns ignored, over 2000 ns reset.
// - Any reset condition drives the warm reset pin low.
// - Outside party pulling warm reset pin low requests a device reset.
// - Warm reset pin is open drain: pull low or release only.
// - Warm reset pin lows under 475 ns rejected, over 2000 ns reset.
// - Pin held low at least 2256 cycles after power-on reset release.
// - Other resets hold the pin low at least 32 bus clock periods.
// - Exception flag 15 on power-up, flag 13 on watchdog or debugger.
// - Exception flags 5 self-test CPU reset, 4 software, 3 external.
// - Global flag 0 on oscillator failure, flags 8 and 9 on slip.
package pus_pkg;
  localparam int CLK_MHZ = 250;
  localparam int FILT_MIN_NS = 475;
  localparam int FILT_MAX_NS = 2000;
  // Least time rounds up; 119 cycles sits well inside the 500 cycle ceiling
  localparam int FILT_CYC = (FILT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int OSC_CYC = 1032;
  localparam int FUSE_CYC = 1160;
  localparam int PUMP_CYC = 688;
  localparam int BANK_CYC = 617;
  localparam int POR_HOLD_CYC = 2256;
  localparam int WARM_HOLD_CYC = 32;
  localparam int CNT_W = 12;
  localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [3:0] EXC_OFS = 4'h0;
  localparam logic [3:0] GLB_OFS = 4'h4;
  localparam logic [3:0] CTL_OFS = 4'h8;
  localparam logic [3:0] PHS_OFS = 4'hc;
  localparam int EXC_POR = 15;
  localparam int EXC_WDG = 13;
  localparam int EXC_STC = 5;
  localparam int EXC_SW = 4;
  localparam int EXC_EXT = 3;
  localparam int GLB_OSC = 0;
  localparam int GLB_SLIP0 = 8;
  localparam int GLB_SLIP1 = 9;
  localparam int CTL_SW_RST = 0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OSC = 3'h1,
    ST_FUSE = 3'h3,
    ST_PUMP = 3'h2,
    ST_BANK = 3'h6,
    ST_RUN = 3'h7,
    ST_WARM = 3'h5
  } pus_state_t;
endpackage

// ===== logic/pus_sequencer.sv
// Purpose: Power-up sequencer, warm reset pin control and reset cause flags
// Assumes: all inputs synchronous to clk; bench resolves the open-drain wire
// Notes: ce low freezes every flop, the bus slave included
`timescale 1ns/10ps
module pus_sequencer #(
  parameter int OSC_CYC = pus_pkg::OSC_CYC,
  parameter int FUSE_CYC = pus_pkg::FUSE_CYC,
  parameter int PUMP_CYC = pus_pkg::PUMP_CYC,
  parameter int BANK_CYC = pus_pkg::BANK_CYC,
  parameter int POR_HOLD_CYC = pus_pkg::POR_HOLD_CYC,
  parameter int WARM_HOLD_CYC = pus_pkg::WARM_HOLD_CYC,
  parameter int FILT_CYC = pus_pkg::FILT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic supply_io_good,
  input wire logic supply_core_good,
  input wire logic power_on_reset_in_n,
  input wire logic warm_reset_pin_n_i,
  output logic warm_reset_pin_n_o,
  output logic warm_reset_pin_n_oe,
  input wire logic osc_fail,
  input wire logic pll_slip,
  input wire logic watchdog_reset_req,
  input wire logic debug_reset_req,
  input wire logic self_test_cpu_reset,
  output logic cpu_reset_n,
  output logic [31:0] cpu_boot_addr,
  output logic osc_enable,
  output logic fuse_autoload_phase,
  output logic pump_enable,
  output logic bank_enable,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int CW = pus_pkg::CNT_W;

  pus_pkg::pus_state_t state;
  pus_pkg::pus_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] hold;
  logic [CW-1:0] next_hold;
  logic [1:0] raw_low;
  logic [1:0] filt_low;
  logic [CW-1:0] filt_cnt [2];
  logic start_ok;
  logic ext_req;
  logic sw_req;
  logic warm_evt;
  logic por_evt;
  logic acc_wr;
  logic [31:0] be_mask;
  logic [31:0] rd_mux;
  logic [31:0] exc_stat;
  logic [31:0] glb_stat;
  logic [31:0] exc_set;
  logic [31:0] glb_set;
  logic [31:0] exc_clr;
  logic [31:0] glb_clr;

  // Own drive masks the pin filter so the device never triggers itself
  assign raw_low[0] = ~power_on_reset_in_n;
  assign raw_low[1] = ~warm_reset_pin_n_i & ~warm_reset_pin_n_oe;

  // Low level must stay for FILT_CYC cycles; a high sample clears at once
  generate
    for (genvar i = 0; i < 2; i++) begin : g_filt
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          filt_cnt[i] <= '0;
          filt_low[i] <= 1'b0;
        end else if (ce) begin
          if (!raw_low[i]) begin
            filt_cnt[i] <= '0;
            filt_low[i] <= 1'b0;
          end else if (filt_cnt[i] == CW'(FILT_CYC - 1)) begin
            filt_low[i] <= 1'b1;
          end else begin
            filt_cnt[i] <= filt_cnt[i] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // Start condition and warm reset causes
  assign start_ok = supply_io_good & supply_core_good & ~filt_low[0];
  assign ext_req = filt_low[1];
  assign acc_wr = avs_write & ~avs_waitrequest;
  assign sw_req = acc_wr & (avs_address == pus_pkg::CTL_OFS) & avs_byteenable[0]
                & avs_writedata[pus_pkg::CTL_SW_RST];
  assign warm_evt = osc_fail | pll_slip | watchdog_reset_req | debug_reset_req
                  | self_test_cpu_reset | sw_req | ext_req;
  assign por_evt = (state == pus_pkg::ST_IDLE) & start_ok;

  // Phase sequencing; a lost supply or power-on reset aborts to idle
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_hold = (hold != '0) ? hold - 1'b1 : hold;
    case (state)
      pus_pkg::ST_IDLE: begin
        if (start_ok) begin
          next_state = pus_pkg::ST_OSC;
          next_cnt = CW'(OSC_CYC - 1);
          next_hold = CW'(POR_HOLD_CYC - 1);
        end
      end
      pus_pkg::ST_OSC: begin
        if (cnt == '0) begin
          next_state = pus_pkg::ST_FUSE;
          next_cnt = CW'(FUSE_CYC - 1);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      pus_pkg::ST_FUSE: begin
        if (cnt == '0) begin
          next_state = pus_pkg::ST_PUMP;
          next_cnt = CW'(PUMP_CYC - 1);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      pus_pkg::ST_PUMP: begin
        if (cnt == '0) begin
          next_state = pus_pkg::ST_BANK;
          next_cnt = CW'(BANK_CYC - 1);
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      pus_pkg::ST_BANK: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else if (hold == '0) begin
          next_state = pus_pkg::ST_RUN;
        end
      end
      pus_pkg::ST_RUN: begin
        if (warm_evt) begin
          next_state = pus_pkg::ST_WARM;
          next_cnt = CW'(WARM_HOLD_CYC - 1);
        end
      end
      pus_pkg::ST_WARM: begin
        if (warm_evt) begin
          next_cnt = CW'(WARM_HOLD_CYC - 1);
        end else if (cnt == '0) begin
          next_state = pus_pkg::ST_RUN;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = pus_pkg::ST_IDLE;
        next_cnt = '0;
      end
    endcase
    if (!start_ok && state != pus_pkg::ST_IDLE) begin
      next_state = pus_pkg::ST_IDLE;
      next_cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= pus_pkg::ST_IDLE;
      cnt <= '0;
      hold <= '0;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      hold <= next_hold;
    end
  end

  // Outputs follow the next state so each one comes straight from a flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_reset_n <= 1'b0;
      warm_reset_pin_n_oe <= 1'b1;
      warm_reset_pin_n_o <= 1'b0;
      cpu_boot_addr <= pus_pkg::BOOT_ADDR;
      osc_enable <= 1'b0;
      fuse_autoload_phase <= 1'b0;
      pump_enable <= 1'b0;
      bank_enable <= 1'b0;
    end else if (ce) begin
      cpu_reset_n <= (next_state == pus_pkg::ST_RUN);
      warm_reset_pin_n_oe <= (next_state != pus_pkg::ST_RUN);
      warm_reset_pin_n_o <= 1'b0;
      cpu_boot_addr <= pus_pkg::BOOT_ADDR;
      osc_enable <= (next_state != pus_pkg::ST_IDLE);
      fuse_autoload_phase <= (next_state == pus_pkg::ST_FUSE);
      // Pump and bank stay powered once their phase has started, until an abort to idle
      pump_enable <= (next_state == pus_pkg::ST_PUMP) | (next_state == pus_pkg::ST_BANK)
                   | (next_state == pus_pkg::ST_RUN) | (next_state == pus_pkg::ST_WARM);
      bank_enable <= (next_state == pus_pkg::ST_BANK) | (next_state == pus_pkg::ST_RUN)
                   | (next_state == pus_pkg::ST_WARM);
    end
  end

  // Cause flags to set this cycle
  always_comb begin
    exc_set = 32'h0;
    glb_set = 32'h0;
    exc_set[pus_pkg::EXC_POR] = por_evt;
    exc_set[pus_pkg::EXC_WDG] = watchdog_reset_req | debug_reset_req;
    exc_set[pus_pkg::EXC_STC] = self_test_cpu_reset;
    exc_set[pus_pkg::EXC_SW] = sw_req;
    exc_set[pus_pkg::EXC_EXT] = ext_req;
    glb_set[pus_pkg::GLB_OSC] = osc_fail;
    glb_set[pus_pkg::GLB_SLIP0] = pll_slip;
    glb_set[pus_pkg::GLB_SLIP1] = pll_slip;
  end

  // Write one to clear, byte lane gated
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign exc_clr = (acc_wr && avs_address == pus_pkg::EXC_OFS) ?
                   (avs_writedata & be_mask) : 32'h0;
  assign glb_clr = (acc_wr && avs_address == pus_pkg::GLB_OFS) ?
                   (avs_writedata & be_mask) : 32'h0;

  // Only rst_n or software clears; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exc_stat <= pus_pkg::REG_RST;
      glb_stat <= pus_pkg::REG_RST;
    end else if (ce) begin
      exc_stat <= (exc_stat & ~exc_clr) | exc_set;
      glb_stat <= (glb_stat & ~glb_clr) | glb_set;
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    case (avs_address)
      pus_pkg::EXC_OFS: rd_mux = exc_stat;
      pus_pkg::GLB_OFS: rd_mux = glb_stat;
      pus_pkg::PHS_OFS: rd_mux = {28'h0, cpu_reset_n, state};
      default: rd_mux = 32'h0;
    endcase
  end

  // One wait cycle per access; read data is captured as waitrequest drops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= pus_pkg::REG_RST;
    end else if (ce) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rd_mux : 32'h0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // Helper: length of the current low drive and whether it began at power-up
  logic [CW-1:0] low_len;
  logic por_run;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_len <= '0;
      por_run <= 1'b0;
    end else if (ce) begin
      if (!warm_reset_pin_n_oe) begin
        low_len <= '0;
      end else if (low_len != '1) begin
        low_len <= low_len + 1'b1;
      end
      if (por_evt) begin
        por_run <= 1'b1;
      end else if (!warm_reset_pin_n_oe) begin
        por_run <= 1'b0;
      end
    end
  end

  seq_start_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    (state == pus_pkg::ST_IDLE && !start_ok) |=> state == pus_pkg::ST_IDLE)
    else $error("sequence left idle without start condition");

  osc_first_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    (state == pus_pkg::ST_IDLE ##1 state != pus_pkg::ST_IDLE) |-> state == pus_pkg::ST_OSC)
    else $error("first phase is not oscillator start-up");

  phase_order_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    ($past(state) == pus_pkg::ST_FUSE && state != pus_pkg::ST_FUSE) |->
    (state == pus_pkg::ST_PUMP && $past(cnt) == '0) || state == pus_pkg::ST_IDLE)
    else $error("fuse phase left early or out of order");

  cpu_release_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $rose(cpu_reset_n) |-> ($past(state) == pus_pkg::ST_BANK
    || $past(state) == pus_pkg::ST_WARM) && cpu_boot_addr == pus_pkg::BOOT_ADDR)
    else $error("cpu reset released outside bank or warm end");

  por_filt_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $rose(filt_low[0]) |-> $past(filt_cnt[0]) == CW'(FILT_CYC - 1))
    else $error("power-on reset filter fired at wrong count");

  pin_filt_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $rose(filt_low[1]) |-> $past(filt_cnt[1]) == CW'(FILT_CYC - 1))
    else $error("warm pin filter fired at wrong count");

  open_drain_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    !cpu_reset_n |-> warm_reset_pin_n_oe && !warm_reset_pin_n_o)
    else $error("pin not pulled low while cpu in reset");

  warm_hold_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $fell(warm_reset_pin_n_oe) |-> $past(low_len) >= CW'(WARM_HOLD_CYC - 1))
    else $error("warm reset pin released too early");

  por_hold_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    ($fell(warm_reset_pin_n_oe) && $past(por_run)) |->
    $past(low_len) >= CW'(POR_HOLD_CYC - 1))
    else $error("pin released too soon after power-on reset");

  flag_set_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    pll_slip |=> glb_stat[pus_pkg::GLB_SLIP0] && glb_stat[pus_pkg::GLB_SLIP1])
    else $error("slip flags not set");

  ext_flag_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    ext_req |=> exc_stat[pus_pkg::EXC_EXT] && state == pus_pkg::ST_WARM
    || state == pus_pkg::ST_IDLE || $past(state) != pus_pkg::ST_RUN)
    else $error("external reset not recorded");
endmodule

// ===== test/pus_board.sv
// Purpose: Board model: supply supervisor and warm reset pin wiring
// Assumes: bench commands change just after a rising clk edge
// Notes: the pin has a pull-up, so a released pin reads high
`timescale 1ns/10ps
module pus_board (
  input wire logic supply_ok,
  input wire logic por_release,
  input wire logic ext_pull,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic supply_io_good,
  output logic supply_core_good,
  output logic power_on_reset_in_n,
  output logic pin_n
);
  // Both rails follow one command; their order never matters to the device
  assign supply_io_good = supply_ok;
  assign supply_core_good = supply_ok;
  // Supervisor keeps reset low whenever the rails are out of range
  assign power_on_reset_in_n = supply_ok & por_release;
  // Wired-AND with pull-up: whoever pulls low wins, nobody drives high
  assign pin_n = ~((pin_oe & ~pin_o) | ext_pull);
endmodule

// ===== test/test_power_up_reset_sequencer.sv
// Purpose: Self-checking bench for the power-up reset sequencer
// Assumes: default phase counts, so a full power-up takes about 3500 cycles
// Notes: outputs are sampled at rising edges, inputs change by NBA there
`timescale 1ns/10ps
module test_power_up_reset_sequencer;
  localparam logic [31:0] MSK [7] = '{32'h1, 32'h300, 32'h2000, 32'h2000, 32'h20, 32'h10, 32'h8};
  // Longest low that must be ignored, and a low just past the limit that must reset
  localparam int SHORT_CYC = (pus_pkg::FILT_MIN_NS * pus_pkg::CLK_MHZ) / 1000;
  localparam int LONG_CYC = (pus_pkg::FILT_MAX_NS * pus_pkg::CLK_MHZ) / 1000 + 1;
  logic clk, rst_n, supply_ok, por_release, ext_pull, sup_io, sup_core, por_n, pin_n;
  logic pin_o, pin_oe, cpu_reset_n, osc_on, fuse_on, pump_on, bank_on, wait_req, rd_en, wr_en;
  logic [4:0] cause;
  logic [31:0] boot_addr, rdata, wdata, d;
  logic [3:0] addr;
  logic [3:0] be;
  logic ce;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  pus_board board (.supply_ok(supply_ok), .por_release(por_release), .ext_pull(ext_pull),
    .pin_o(pin_o), .pin_oe(pin_oe), .supply_io_good(sup_io), .supply_core_good(sup_core),
    .power_on_reset_in_n(por_n), .pin_n(pin_n));

  pus_sequencer dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .supply_io_good(sup_io), .supply_core_good(sup_core), .power_on_reset_in_n(por_n),
    .warm_reset_pin_n_i(pin_n), .warm_reset_pin_n_o(pin_o), .warm_reset_pin_n_oe(pin_oe),
    .osc_fail(cause[0]), .pll_slip(cause[1]), .watchdog_reset_req(cause[2]),
    .debug_reset_req(cause[3]), .self_test_cpu_reset(cause[4]), .cpu_reset_n(cpu_reset_n),
    .cpu_boot_addr(boot_addr), .osc_enable(osc_on), .fuse_autoload_phase(fuse_on),
    .pump_enable(pump_on), .bank_enable(bank_on), .avs_address(addr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_req));

  // Free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard; a full run needs about 8500 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      finish_test;
    end
  end

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Avalon master: hold the request until waitrequest is sampled low
  task bus_rd(input logic [3:0] a, output logic [31:0] q);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    q = rdata;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask

  task bus_wr(input logic [3:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  // Full power-up from bad rails; counts each phase while CPU reset is held
  task t_power_up;
    int n_osc, n_fuse, n_pump, n_bank, n_all, bad_pin, n_low;
    n_osc = 0;
    n_fuse = 0;
    n_pump = 0;
    n_bank = 0;
    n_all = 0;
    bad_pin = 0;
    supply_ok <= 1'b0;
    por_release <= 1'b1;
    repeat (10) @(posedge clk);
    check("osc_enable with rails bad", 32'h0, {31'h0, osc_on});
    supply_ok <= 1'b1;
    @(posedge clk);
    while (cpu_reset_n !== 1'b1 && n_all < 5000) begin
      @(posedge clk);
      n_all++;
      if (cpu_reset_n === 1'b0 && osc_on === 1'b1 && pin_n !== 1'b0) bad_pin++;
      if (osc_on === 1'b1 && fuse_on === 1'b0 && pump_on === 1'b0) n_osc++;
      if (fuse_on === 1'b1) n_fuse++;
      if (pump_on === 1'b1 && bank_on === 1'b0) n_pump++;
      if (bank_on === 1'b1 && cpu_reset_n === 1'b0) n_bank++;
    end
    n_low = n_osc + n_fuse + n_pump + n_bank;
    check("osc phase cycles", 32'(pus_pkg::OSC_CYC), n_osc);
    check("fuse phase cycles", 32'(pus_pkg::FUSE_CYC), n_fuse);
    check("pump phase cycles", 32'(pus_pkg::PUMP_CYC), n_pump);
    check("bank phase long enough", 32'h1, {31'h0, n_bank >= pus_pkg::BANK_CYC});
    check("pin low long enough", 32'h1, {31'h0, n_low >= pus_pkg::POR_HOLD_CYC});
    check("pin released early", 32'h0, bad_pin);
    check("cpu_reset_n released", 32'h1, {31'h0, cpu_reset_n});
    check("boot address", 32'h0, boot_addr);
    bus_rd(pus_pkg::PHS_OFS, d);
    check("phase register in run", 32'hf, d);
    bus_rd(pus_pkg::EXC_OFS, d);
    check("power-up flag", 32'h8000, d & 32'h8000);
    $display("test power_up done");
  endtask

  // Short low on the power-on reset is ignored, a long one restarts power-up
  task t_por_glitch;
    por_release <= 1'b0;
    repeat (SHORT_CYC) @(posedge clk);
    por_release <= 1'b1;
    repeat (6) @(posedge clk);
    check("cpu after short por low", 32'h1, {31'h0, cpu_reset_n});
    por_release <= 1'b0;
    repeat (LONG_CYC) @(posedge clk);
    check("cpu after long por low", 32'h0, {31'h0, cpu_reset_n});
    check("pin after long por low", 32'h0, {31'h0, pin_n});
    t_power_up;
    $display("test por_glitch done");
  endtask

  // Every warm reset cause in turn, then flag persistence and clearing
  task t_causes;
    int n, lo, bad;
    // A cause seen while the clock enable is low must change nothing
    ce <= 1'b0;
    cause <= 5'h1;
    @(posedge clk);
    ce <= 1'b1;
    cause <= 5'h0;
    repeat (3) @(posedge clk);
    check("cpu after cause with ce low", 32'h1, {31'h0, cpu_reset_n});
    ext_pull <= 1'b1;
    repeat (SHORT_CYC) @(posedge clk);
    ext_pull <= 1'b0;
    repeat (6) @(posedge clk);
    check("cpu after short pin low", 32'h1, {31'h0, cpu_reset_n});
    for (int i = 0; i < 7; i++) begin
      n = 0;
      lo = 0;
      bad = 0;
      if (i < 5) begin
        // Watchdog and debugger share one flag: clear it so the debugger case can fail
        if (i == 3) begin
          be <= 4'h2;
          bus_wr(pus_pkg::EXC_OFS, 32'h2000);
          be <= 4'hf;
          bus_rd(pus_pkg::EXC_OFS, d);
          check("watchdog flag cleared", 32'h0, d & 32'h2000);
        end
        cause <= 5'h1 << i;
        @(posedge clk);
        cause <= 5'h0;
      end else if (i == 5) begin
        bus_wr(pus_pkg::CTL_OFS, 32'h1);
      end else begin
        // Hold the pin low until the device answers; it must within the long limit
        ext_pull <= 1'b1;
        while (cpu_reset_n !== 1'b0 && n < LONG_CYC) begin
          @(posedge clk);
          n++;
        end
        ext_pull <= 1'b0;
        check("external reset delay", 32'h1, {31'h0, n > SHORT_CYC && n < LONG_CYC});
      end
      while (cpu_reset_n !== 1'b0 && n < 300) begin
        @(posedge clk);
        n++;
      end
      while (cpu_reset_n === 1'b0 && lo < 300) begin
        @(posedge clk);
        lo++;
        if (cpu_reset_n === 1'b0 && pin_n !== 1'b0) bad++;
      end
      check("warm reset length", 32'h1, {31'h0, lo >= pus_pkg::WARM_HOLD_CYC && lo < 300});
      check("pin during warm reset", 32'h0, bad);
      bus_rd(i < 2 ? pus_pkg::GLB_OFS : pus_pkg::EXC_OFS, d);
      check("cause flag", MSK[i], d & MSK[i]);
    end
    bus_rd(pus_pkg::EXC_OFS, d);
    check("exception flags kept", 32'ha038, d);
    bus_rd(pus_pkg::GLB_OFS, d);
    check("global flags kept", 32'h301, d);
    be <= 4'h1;
    bus_wr(pus_pkg::EXC_OFS, 32'hffff_ffff);
    be <= 4'hf;
    bus_rd(pus_pkg::EXC_OFS, d);
    check("byte lane clear", 32'ha000, d);
    bus_wr(pus_pkg::EXC_OFS, 32'hffff_ffff);
    bus_wr(pus_pkg::GLB_OFS, 32'hffff_ffff);
    bus_wr(pus_pkg::PHS_OFS, 32'h0);
    bus_rd(pus_pkg::EXC_OFS, d);
    check("exception flags cleared", 32'h0, d);
    bus_rd(pus_pkg::GLB_OFS, d);
    check("global flags cleared", 32'h0, d);
    bus_rd(pus_pkg::PHS_OFS, d);
    check("phase register read only", 32'hf, d);
    bus_rd(4'h6, d);
    check("unmapped read", 32'h0, d);
    $display("test causes done");
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    supply_ok = 1'b0;
    por_release = 1'b0;
    ext_pull = 1'b0;
    cause = 5'h0;
    addr = 4'h0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdata = 32'h0;
    ce = 1'b1;
    be = 4'hf;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_power_up;
    t_por_glitch;
    t_causes;
    finish_test;
  end
endmodule
